// ==== design/lrm_consts.svh ====
// Constants for the linear-regulator mask and load measurement registers.
// Assumes inclusion by the package and by every design module.
`ifndef LRM_CONSTS_SVH
`define LRM_CONSTS_SVH
`define LRM_ADDR_MASK        8'h23
`define LRM_ADDR_SEL         8'h24
`define LRM_ADDR_RES_HI      8'h25
`define LRM_ADDR_RES_LO      8'h26
`define LRM_BIT_L1_PGF       7
`define LRM_BIT_L1_PGR       6
`define LRM_BIT_L1_ILIM      4
`define LRM_BIT_L0_PGF       3
`define LRM_BIT_L0_PGR       2
`define LRM_BIT_L0_ILIM      0
`define LRM_MASK_WMASK       8'hdd
`define LRM_MASK_RESET       8'h00
`define LRM_SEL_RESET        1'b0
`define LRM_RES_RESET        9'h000
`define LRM_RES_MAX          9'h1ff
`define LRM_LSB_MA           20
`define LRM_FULL_SCALE_MA    10220
`endif

// ==== design/lrm_irq_gate.sv ====
// Edge detection and masking for one linear regulator's interrupt events.
// Assumes status inputs are synchronous to sys_clk.
`timescale 1ns/1ns
`include "lrm_consts.svh"
module lrm_irq_gate
   import lrm_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic reset_n,
   input  wire logic pg_state,
   input  wire logic ilim_state,
   input  wire logic pg_invalid_mask,
   input  wire logic pg_valid_mask,
   input  wire logic ilim_mask,
   output logic      pg_irq,
   output logic      ilim_irq
);
   logic pg_prev_reg;
   logic ilim_prev_reg;

   // Previous levels for edge detection
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         pg_prev_reg   <= 1'b0;
         ilim_prev_reg <= 1'b0;
      end else begin
         pg_prev_reg   <= pg_state;
         ilim_prev_reg <= ilim_state;
      end
   end

   // Masks gate only the event pulses, never the levels
   assign pg_irq   = (pg_prev_reg & ~pg_state & ~pg_invalid_mask) |
                     (~pg_prev_reg & pg_state & ~pg_valid_mask);
   assign ilim_irq = ~ilim_prev_reg & ilim_state & ~ilim_mask;
endmodule : lrm_irq_gate

// ==== design/lrm_meas_ctrl.sv ====
// Handshake with the analog measurement front end.
// Assumes front end answers meas_done with a one-cycle pulse and data.
`timescale 1ns/1ns
`include "lrm_consts.svh"
module lrm_meas_ctrl
   import lrm_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   input  wire logic        start,
   output logic             meas_start,
   input  wire logic        meas_done,
   output logic             busy,
   output logic             capture
);
   lrm_meas_state_t state_reg;
   lrm_meas_state_t state_next;

   // A new start restarts the measurement, even while busy
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         LRM_IDLE: if (start) state_next = LRM_REQ;
         LRM_REQ:  state_next = start ? LRM_REQ : LRM_WAIT;
         LRM_WAIT: begin
            if (start)          state_next = LRM_REQ;
            else if (meas_done) state_next = LRM_IDLE;
         end
         default:  state_next = LRM_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) state_reg <= LRM_IDLE;
      else          state_reg <= state_next;
   end

   assign meas_start = (state_reg == LRM_REQ);
   assign busy       = (state_reg != LRM_IDLE);
   // A done in the start cycle or in LRM_REQ is dropped; in LRM_WAIT it is captured
   assign capture    = (state_reg == LRM_WAIT) & meas_done & ~start;
endmodule : lrm_meas_ctrl

// ==== design/lrm_pkg.sv ====
// Types shared by the load measurement register group.
// Assumes lrm_consts.svh is on the include path.
`include "lrm_consts.svh"
package lrm_pkg;
   typedef enum logic [1:0] {
      LRM_IDLE = 2'b00,
      LRM_REQ  = 2'b01,
      LRM_WAIT = 2'b11
   } lrm_meas_state_t;
   typedef logic [8:0] lrm_result_t;
endpackage : lrm_pkg

// ==== design/lrm_regs.sv ====
// Linear-regulator interrupt masks and buck load current measurement.
// Assumes a serial interface decoder that gives one-cycle strobes.
//
// Contract
// - Mask bit 7 blocks regulator-1 power-good invalid interrupt.
// - Mask bit 6 blocks regulator-1 power-good valid interrupt.
// - Mask bit 4 blocks regulator-1 current-limit interrupt.
// - Mask bit 3 blocks regulator-0 power-good invalid interrupt.
// - Mask bit 2 blocks regulator-0 power-good valid interrupt.
// - Mask bit 0 blocks regulator-0 current-limit interrupt.
// - Masks gate interrupts only; status bits keep tracking conditions.
// - Mask bits 5 and 1 are reserved and read zero.
// - Select bit 0 picks converter 0 or 1, resets to 0.
// - Each select write starts a new measurement.
// - Master selection reports the summed master and slave current; the code sums only when dual_phase is set, else the master reports its own.
// - Slave selection reports only its own current.
// - Result high bit 0 holds result bit 8, others zero.
// - Result unsigned, 20 mA per LSB, 10.22 A full scale.
// - Result low holds result bits 7:0, read-only.
`timescale 1ns/1ns
`include "lrm_consts.svh"
module lrm_regs
   import lrm_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       reset_n,
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   output logic            reg_hit,
   input  wire logic       linreg0_power_good_state,
   input  wire logic       linreg1_power_good_state,
   input  wire logic       linreg0_overcurrent_state,
   input  wire logic       linreg1_overcurrent_state,
   output logic            linreg0_power_good_irq,
   output logic            linreg1_power_good_irq,
   output logic            linreg0_overcurrent_irq,
   output logic            linreg1_overcurrent_irq,
   input  wire logic       dual_phase,
   input  wire logic       buck1_is_master,
   output logic            meas_start,
   output logic            meas_buck_sel,
   output logic            meas_sum_phases,
   input  wire logic       meas_done,
   input  wire logic [8:0] meas_current,
   output logic            meas_busy,
   output logic            result_update
);
   logic [7:0]  mask_reg;
   logic        sel_reg;
   lrm_result_t result_reg;
   logic [7:0]  rdata_reg;
   logic        start_pulse;
   logic        capture;

   // Address decode
   wire hit_mask = (reg_addr == `LRM_ADDR_MASK);
   wire hit_sel  = (reg_addr == `LRM_ADDR_SEL);
   wire hit_hi   = (reg_addr == `LRM_ADDR_RES_HI);
   wire hit_lo   = (reg_addr == `LRM_ADDR_RES_LO);
   wire wr_mask  = reg_wr & hit_mask;
   wire wr_sel   = reg_wr & hit_sel;
   assign reg_hit = hit_mask | hit_sel | hit_hi | hit_lo;

   // Saturate at full scale; the front end is trusted to be 9 bits
   function automatic lrm_result_t lrm_clip(input logic [8:0] v);
      lrm_clip = (v > `LRM_RES_MAX) ? `LRM_RES_MAX : v;
   endfunction : lrm_clip

   // Mask register; reserved bits never store
   always_ff @(posedge sys_clk) begin
      if (!reset_n)
         mask_reg <= `LRM_MASK_RESET;
      else if (wr_mask)
         mask_reg <= reg_wdata & `LRM_MASK_WMASK;
   end

   // Select register; the write itself is the start trigger
   always_ff @(posedge sys_clk) begin
      if (!reset_n)
         sel_reg <= `LRM_SEL_RESET;
      else if (wr_sel)
         sel_reg <= reg_wdata[0];
   end
   assign start_pulse = wr_sel;

   lrm_meas_ctrl u_meas (
      .sys_clk    (sys_clk),
      .reset_n    (reset_n),
      .start      (start_pulse),
      .meas_start (meas_start),
      .meas_done  (meas_done),
      .busy       (meas_busy),
      .capture    (capture)
   );

   // Selection to front end; sum only for the master of a pair
   assign meas_buck_sel   = sel_reg;
   assign meas_sum_phases = dual_phase &
                            (sel_reg == buck1_is_master);

   // One register for all nine bits keeps both bytes coherent
   always_ff @(posedge sys_clk) begin
      if (!reset_n)
         result_reg <= `LRM_RES_RESET;
      else if (capture)
         result_reg <= lrm_clip(meas_current);
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) result_update <= 1'b0;
      else          result_update <= capture;
   end

   // Read mux; unmapped addresses read zero
   wire [7:0] rd_mux =
      hit_mask ? mask_reg :
      hit_sel  ? {7'h00, sel_reg} :
      hit_hi   ? {7'h00, result_reg[8]} :
      hit_lo   ? result_reg[7:0] :
                 8'h00;

   always_ff @(posedge sys_clk) begin
      if (!reset_n)    rdata_reg <= 8'h00;
      else if (reg_rd) rdata_reg <= rd_mux;
   end
   assign reg_rdata = rdata_reg;

   // Per-regulator gating; status inputs pass untouched
   lrm_irq_gate u_gate0 (
      .sys_clk         (sys_clk),
      .reset_n         (reset_n),
      .pg_state        (linreg0_power_good_state),
      .ilim_state      (linreg0_overcurrent_state),
      .pg_invalid_mask (mask_reg[`LRM_BIT_L0_PGF]),
      .pg_valid_mask   (mask_reg[`LRM_BIT_L0_PGR]),
      .ilim_mask       (mask_reg[`LRM_BIT_L0_ILIM]),
      .pg_irq          (linreg0_power_good_irq),
      .ilim_irq        (linreg0_overcurrent_irq)
   );

   lrm_irq_gate u_gate1 (
      .sys_clk         (sys_clk),
      .reset_n         (reset_n),
      .pg_state        (linreg1_power_good_state),
      .ilim_state      (linreg1_overcurrent_state),
      .pg_invalid_mask (mask_reg[`LRM_BIT_L1_PGF]),
      .pg_valid_mask   (mask_reg[`LRM_BIT_L1_PGR]),
      .ilim_mask       (mask_reg[`LRM_BIT_L1_ILIM]),
      .pg_irq          (linreg1_power_good_irq),
      .ilim_irq        (linreg1_overcurrent_irq)
   );
endmodule : lrm_regs

// ==== verification/lrm_fe_model.sv ====
// Measurement front end model: answers each start after DLY cycles.
// Assumes meas_start is high for one cycle per request.
`timescale 1ns/1ns
module lrm_fe_model #(parameter int DLY = 5) (
   input  wire logic       sys_clk,
   input  wire logic       reset_n,
   input  wire logic       meas_start,
   input  wire logic       meas_buck_sel,
   input  wire logic       meas_sum_phases,
   input  wire logic [8:0] cur0,
   input  wire logic [8:0] cur1,
   output logic            meas_done,
   output logic [8:0]      meas_current
);
   int cnt;
   // Pair reports the sum, a lone phase only its own current
   wire logic [8:0] val = meas_sum_phases ? cur0 + cur1
                        : meas_buck_sel ? cur1 : cur0;
   // Restart on each start; data toggles outside the done pulse
   always_ff @(posedge sys_clk) begin
      meas_done <= 1'b0;
      meas_current <= ~meas_current;
      if (!reset_n) begin
         cnt <= 0;
         meas_current <= 9'h000;
      end else if (meas_start) cnt <= DLY;
      else if (cnt > 0) begin
         cnt <= cnt - 1;
         meas_done <= cnt == 1;
         if (cnt == 1) meas_current <= val;
      end
   end
endmodule : lrm_fe_model

// ==== verification/lrm_regs_props.sv ====
// Checker for the mask and load measurement register group.
// Assumes it is bound to lrm_regs and sees only its ports.
`timescale 1ns/1ns
module lrm_regs_props
   import lrm_pkg::*;
(
   input wire logic       sys_clk,
   input wire logic       reset_n,
   input wire logic [7:0] reg_addr,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic       linreg1_power_good_state,
   input wire logic       linreg1_power_good_irq,
   input wire logic       meas_start,
   input wire logic       meas_buck_sel,
   input wire logic       meas_done,
   input wire logic       result_update
);
   logic [7:0] mask_reg;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   sequence rd_at(a); reg_rd && reg_addr == a; endsequence
   sequence pg_edge; $changed(linreg1_power_good_state) && $past(reset_n);
   endsequence
   // Shadow of host mask writes; reserved bits never stick
   always_ff @(posedge sys_clk)
      if (!reset_n) mask_reg <= 8'h00;
      else if (reg_wr && reg_addr == 8'h23) mask_reg <= reg_wdata & 8'hdd;
   AST_PGF: assert property (pg_edge ##0 !linreg1_power_good_state
      |-> linreg1_power_good_irq == !mask_reg[7]) else $error("pg fall irq");
   AST_PGR: assert property (pg_edge ##0 linreg1_power_good_state
      |-> linreg1_power_good_irq == !mask_reg[6]) else $error("pg rise irq");
   AST_PGQ: assert property (!$changed(linreg1_power_good_state)
      && $past(reset_n) |-> !linreg1_power_good_irq) else $error("pg irq");
   AST_MSK: assert property (rd_at(8'h23) |=>
      reg_rdata == mask_reg) else $error("mask read");
   AST_SEL: assert property (rd_at(8'h24) |=>
      reg_rdata == {7'h00, $past(meas_buck_sel)}) else $error("select read");
   AST_GO: assert property (reg_wr && reg_addr == 8'h24 |=>
      meas_start) else $error("no start");
   AST_HI: assert property (rd_at(8'h25) |=>
      reg_rdata[7:1] == 7'h00) else $error("high byte");
   AST_UPD: assert property (result_update |->
      $past(meas_done)) else $error("update");
endmodule : lrm_regs_props
bind lrm_regs lrm_regs_props lrm_regs_props_inst (.*);

// ==== verification/tb.sv ====
// Bench for the mask and load measurement registers over the strobe bus.
// Assumes lrm_fe_model answers each measurement start.
`timescale 1ns/1ns
`define CHK(n, g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("wrong value %s exp %h got %h", n, e, g); end end
module tb;
   logic       sys_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic       pg0 = 1'b0, pg1 = 1'b0, oc0 = 1'b0, oc1 = 1'b0, sel;
   logic       dual_phase = 1'b0, buck1_is_master = 1'b1, i_pg0, i_pg1;
   logic       i_oc0, i_oc1, reg_hit, meas_start, meas_buck_sel, meas_busy;
   logic       meas_sum_phases, meas_done, result_update;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic [8:0] meas_current, cur0 = 9'h1a5, cur1 = 9'h033;
   logic [7:0] mtab [4] = '{8'hff, 8'h00, 8'h99, 8'h66};
   int         error_cnt = 0, checks = 0;
   // Free-running clock, 8 ns
   always #4 sys_clk = ~sys_clk;
   lrm_regs lrm_regs_inst (.*, .linreg0_power_good_state(pg0),
      .linreg1_power_good_state(pg1), .linreg0_overcurrent_state(oc0),
      .linreg1_overcurrent_state(oc1), .linreg0_power_good_irq(i_pg0),
      .linreg1_power_good_irq(i_pg1), .linreg0_overcurrent_irq(i_oc0),
      .linreg1_overcurrent_irq(i_oc1));
   lrm_fe_model lrm_fe_model_inst (.*);
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
      @(negedge sys_clk);
      reg_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge sys_clk);
      {reg_addr, reg_rd} = {a, 1'b1};
      @(negedge sys_clk);
      reg_rd = 1'b0;
      `CHK("rdata", reg_rdata, e)
      `CHK("hit", reg_hit, a inside {[8'h23:8'h26]})
   endtask : rd
   // Rise then fall on every status line, irq seen in the same cycle
   task automatic edges(input logic [7:0] m);
      for (int v = 1; v >= 0; v--) begin
         @(negedge sys_clk);
         {pg0, pg1, oc0, oc1} = {4{v[0]}};
         #1;
         `CHK("pg1 irq", i_pg1, v ? !m[6] : !m[7])
         `CHK("oc1 irq", i_oc1, v ? !m[4] : 1'b0)
         `CHK("pg0 irq", i_pg0, v ? !m[2] : !m[3])
         `CHK("oc0 irq", i_oc0, v ? !m[0] : 1'b0)
      end
   endtask : edges
   // Upper select bits are written as ones to prove they drop
   task automatic meas(input logic s);
      logic [8:0] e;
      e = dual_phase && s == buck1_is_master ? cur0 + cur1 : s ? cur1 : cur0;
      wr(8'h24, {7'h7f, s});
      `CHK("busy", meas_busy, 1'b1)
      for (int i = 0; i < 40 && result_update !== 1'b1; i++)
         @(negedge sys_clk);
      `CHK("update", result_update, 1'b1)
      `CHK("idle", meas_busy, 1'b0)
      rd(8'h25, {7'h00, e[8]});
      rd(8'h26, e[7:0]);
      rd(8'h24, {7'h00, s});
   endtask : meas
   task automatic end_of_test;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_of_test
   // Main sequence: reset values, masks, measurements, refusals
   initial begin
      repeat (16) @(negedge sys_clk);
      reset_n = 1'b1;
      rd(8'h24, 8'h00);
      rd(8'h25, 8'h00);
      for (int k = 0; k < 4; k++) begin
         wr(8'h23, mtab[k]);
         rd(8'h23, mtab[k] & 8'hdd);
         edges(mtab[k]);
      end
      for (int k = 0; k < 4; k++) begin
         {dual_phase, sel} = k[1:0];
         meas(sel);
      end
      buck1_is_master = 1'b0;
      wr(8'h24, 8'h01);
      meas(1'b0);
      wr(8'h26, 8'h00);
      rd(8'h26, 8'hd8);
      rd(8'h30, 8'h00);
      end_of_test();
   end
   // Watchdog, far beyond the roughly 130 cycles the tests need
   initial begin
      #20000;
      error_cnt++;
      end_of_test();
   end
endmodule : tb
